// *** logic/pcr_regs.sv ***
// Pin function and converter power register bank
//
// What this block does
// - Two 24-bit pin registers, twelve 4-bit fields, one per pin.
// - Low register holds pins 0 to 5, pin 0 in bits 3:0.
// - High register holds pins 6 to 11, pin 6 in bits 3:0.
// - Field top bit inverts the pin signal in its function.
// - Pull-up on only for GPIO input or serial data input.
// - Codes 0 to 4: debounced in, raw in, out, open-collector, serial.
// - Codes 8 to 12: same five functions, inverted.
// - Code 15 routes pins 2, 3, 8 and 9 to the auxiliary converter; other pins get no function.
// - Smoothing: 4-bit hyst, 5-bit hyst, all bypassed, filter bypassed.
// - Power register: smoothing 9:8, ADC 7, buffer 6, ref 5, DACs 3:0.
// - Aux enable register bit 15 turns the converter on.
// - Oscillator register bit 2 powers the crystal oscillator down.
// - Aux channels: pin 9 ch0, pin 2 ch1, pin 3 ch2, pin 8 ch3.
// - Serial mode: pins 0-5 inputs, pins 6-11 outputs.
// - Low-pass filter active by default while converter enabled.
`timescale 1ns/1ps
module pcr_regs (
   // Clock and reset
   input  wire logic                              clk,
   input  wire logic                              rst,
   // Control port register access
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   input  wire logic [pcr_pkg::PCR_ADDR_W-1:0]    reg_addr,
   input  wire logic [pcr_pkg::PCR_DATA_W-1:0]    reg_wdata,
   output logic      [pcr_pkg::PCR_DATA_W-1:0]    reg_rdata,
   output logic                                   reg_rvalid,
   // Per-pin function selection
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_gpi_debounced,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_gpi_raw,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_gpo,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_open_collector,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_serial_in,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_serial_out,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_aux_in,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_invert,
   output logic      [pcr_pkg::PCR_NUM_PINS-1:0]  pin_pullup_en,
   // Auxiliary converter
   output logic      [pcr_pkg::PCR_AUX_CHANS-1:0] aux_channel_connect,
   output logic                                   aux_converter_enable,
   output logic      [1:0]                        aux_smoothing_select,
   output logic                                   aux_lpf_active,
   output logic                                   aux_hyst_active,
   output logic                                   aux_hyst_5bit,
   // Power control
   output logic                                   adc_power_down,
   output logic                                   vref_buffer_power_down,
   output logic                                   vref_power_down,
   output logic                                   dac0_power_down,
   output logic                                   dac1_power_down,
   output logic                                   dac2_power_down,
   output logic                                   dac3_power_down,
   output logic                                   oscillator_power_down,
   output logic      [1:0]                        dac_init_code
);
   import pcr_pkg::*;

   localparam int NP = PCR_NUM_PINS;

   // ==========================================================
   // Storage: only defined bits are held, reserved ones read zero
   logic [PCR_DATA_W-1:0] pin_low_q;
   logic [PCR_DATA_W-1:0] pin_high_q;
   logic [1:0]            smooth_q;
   logic [2:0]            ref_pd_q;
   logic [3:0]            dac_pd_q;
   logic                  aux_en_q;
   logic                  osc_pd_q;
   logic [1:0]            dac_init_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_low_q  <= PCR_RST_PIN;
         pin_high_q <= PCR_RST_PIN;
      end else if (reg_wr) begin
         if (reg_addr == PCR_ADDR_PIN_LOW)
            pin_low_q <= reg_wdata;
         if (reg_addr == PCR_ADDR_PIN_HIGH)
            pin_high_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         smooth_q <= PCR_RST_2B;
         ref_pd_q <= 3'h0;
         dac_pd_q <= PCR_RST_4B;
      end else if (reg_wr && reg_addr == PCR_ADDR_PWR) begin
         smooth_q <= reg_wdata[PCR_SMOOTH_LSB +: 2];
         ref_pd_q <= reg_wdata[PCR_VREF_PD_BIT +: 3];
         dac_pd_q <= reg_wdata[PCR_DAC3_PD_BIT +: 4];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aux_en_q   <= PCR_RST_BIT;
         osc_pd_q   <= PCR_RST_BIT;
         dac_init_q <= PCR_RST_2B;
      end else if (reg_wr) begin
         if (reg_addr == PCR_ADDR_AUX_EN)
            aux_en_q <= reg_wdata[PCR_AUX_EN_BIT];
         if (reg_addr == PCR_ADDR_OSC)
            osc_pd_q <= reg_wdata[PCR_OSC_PD_BIT];
         // Reserved codes are stored as written; software owns that choice
         if (reg_addr == PCR_ADDR_DAC_INIT)
            dac_init_q <= reg_wdata[PCR_DAC_INIT_LSB +: 2];
      end
   end

   // ==========================================================
   // Read-back, one cycle after the strobe; unmapped reads give zero
   function automatic logic [PCR_DATA_W-1:0] read_mux(
      input logic [PCR_ADDR_W-1:0] a);
      logic [PCR_DATA_W-1:0] v;
      v = '0;
      case (a)
         PCR_ADDR_PIN_LOW:  v = pin_low_q;
         PCR_ADDR_PIN_HIGH: v = pin_high_q;
         PCR_ADDR_PWR: begin
            v[PCR_SMOOTH_LSB +: 2]  = smooth_q;
            v[PCR_VREF_PD_BIT +: 3] = ref_pd_q;
            v[PCR_DAC3_PD_BIT +: 4] = dac_pd_q;
         end
         PCR_ADDR_AUX_EN:   v[PCR_AUX_EN_BIT] = aux_en_q;
         PCR_ADDR_OSC:      v[PCR_OSC_PD_BIT] = osc_pd_q;
         PCR_ADDR_DAC_INIT: v[PCR_DAC_INIT_LSB +: 2] = dac_init_q;
         default:           v = '0;
      endcase
      return v;
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= read_mux(reg_addr);
      end
   end

   // ==========================================================
   // Per-pin decode; register N field sits at nibble (pin mod 6)
   logic [NP-1:0] dec_gpi_deb;
   logic [NP-1:0] dec_gpi_raw;
   logic [NP-1:0] dec_gpo;
   logic [NP-1:0] dec_oc;
   logic [NP-1:0] dec_sin;
   logic [NP-1:0] dec_sout;
   logic [NP-1:0] dec_aux;
   logic [NP-1:0] dec_inv;
   logic [NP-1:0] dec_pu;

   genvar gi;
   generate
      for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
         localparam int NIB = (gi % PCR_PINS_REG) * PCR_CFG_W;
         localparam bit AUXC = (gi == PCR_AUX_PIN_CH0) ||
                               (gi == PCR_AUX_PIN_CH1) ||
                               (gi == PCR_AUX_PIN_CH2) ||
                               (gi == PCR_AUX_PIN_CH3);
         logic [PCR_CFG_W-1:0] cfg;
         assign cfg = (gi < PCR_PINS_REG) ? pin_low_q[NIB +: PCR_CFG_W]
                                          : pin_high_q[NIB +: PCR_CFG_W];
         pcr_pin_decode #(
            .SERIAL_IS_INPUT (gi < PCR_PINS_REG),
            .AUX_CAPABLE     (AUXC)
         ) u_dec (
            .multipurpose_pin_cfg (cfg),
            .sel_gpi_deb          (dec_gpi_deb[gi]),
            .sel_gpi_raw          (dec_gpi_raw[gi]),
            .sel_gpo              (dec_gpo[gi]),
            .sel_open_coll        (dec_oc[gi]),
            .sel_serial_in        (dec_sin[gi]),
            .sel_serial_out       (dec_sout[gi]),
            .sel_aux              (dec_aux[gi]),
            .invert               (dec_inv[gi]),
            .pullup_en            (dec_pu[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Registered outputs; they follow a write by two cycles
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_gpi_debounced  <= {NP{1'b1}};
         pin_gpi_raw        <= '0;
         pin_gpo            <= '0;
         pin_open_collector <= '0;
         pin_serial_in      <= '0;
         pin_serial_out     <= '0;
         pin_aux_in         <= '0;
         pin_invert         <= '0;
         pin_pullup_en      <= {NP{1'b1}};
      end else begin
         pin_gpi_debounced  <= dec_gpi_deb;
         pin_gpi_raw        <= dec_gpi_raw;
         pin_gpo            <= dec_gpo;
         pin_open_collector <= dec_oc;
         pin_serial_in      <= dec_sin;
         pin_serial_out     <= dec_sout;
         pin_aux_in         <= dec_aux;
         pin_invert         <= dec_inv;
         pin_pullup_en      <= dec_pu;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aux_channel_connect <= '0;
      end else begin
         aux_channel_connect <= {dec_aux[PCR_AUX_PIN_CH3],
                                 dec_aux[PCR_AUX_PIN_CH2],
                                 dec_aux[PCR_AUX_PIN_CH1],
                                 dec_aux[PCR_AUX_PIN_CH0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aux_converter_enable <= 1'b0;
         aux_smoothing_select <= PCR_RST_2B;
         aux_lpf_active       <= 1'b0;
         aux_hyst_active      <= 1'b0;
         aux_hyst_5bit        <= 1'b0;
      end else begin
         aux_converter_enable <= aux_en_q;
         aux_smoothing_select <= smooth_q;
         // Filter runs while the converter is enabled, unless one of the bypass codes is chosen
         aux_lpf_active <= aux_en_q && (smooth_q != PCR_SM_BYPASS) &&
                           (smooth_q != PCR_SM_NO_LPF);
         aux_hyst_active <= aux_en_q &&
                            (smooth_q != PCR_SM_BYPASS);
         aux_hyst_5bit   <= (smooth_q == PCR_SM_HYST5);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         adc_power_down         <= 1'b0;
         vref_buffer_power_down <= 1'b0;
         vref_power_down        <= 1'b0;
         dac0_power_down        <= 1'b0;
         dac1_power_down        <= 1'b0;
         dac2_power_down        <= 1'b0;
         dac3_power_down        <= 1'b0;
         oscillator_power_down  <= 1'b0;
         dac_init_code          <= PCR_RST_2B;
      end else begin
         adc_power_down         <= ref_pd_q[2];
         vref_buffer_power_down <= ref_pd_q[1];
         vref_power_down        <= ref_pd_q[0];
         dac0_power_down        <= dac_pd_q[3];
         dac1_power_down        <= dac_pd_q[2];
         dac2_power_down        <= dac_pd_q[1];
         dac3_power_down        <= dac_pd_q[0];
         oscillator_power_down  <= osc_pd_q;
         dac_init_code          <= dac_init_q;
      end
   end
endmodule

// *** logic/pcr_pkg.sv ***
// Package: register map, field layout and reset values of the pin/power bank
package pcr_pkg;
   // ==========================================================
   // Register addresses on the control port
   localparam logic [15:0] PCR_ADDR_PIN_LOW  = 16'h0820;
   localparam logic [15:0] PCR_ADDR_PIN_HIGH = 16'h0821;
   localparam logic [15:0] PCR_ADDR_PWR      = 16'h0822;
   localparam logic [15:0] PCR_ADDR_AUX_EN   = 16'h0824;
   localparam logic [15:0] PCR_ADDR_OSC      = 16'h0826;
   localparam logic [15:0] PCR_ADDR_DAC_INIT = 16'h0827;

   // ==========================================================
   // Widths and counts
   localparam int PCR_ADDR_W     = 16;
   localparam int PCR_DATA_W     = 24;
   localparam int PCR_NUM_PINS   = 12;
   localparam int PCR_PINS_REG   = 6;
   localparam int PCR_CFG_W      = 4;
   localparam int PCR_AUX_CHANS  = 4;

   // ==========================================================
   // Field positions
   localparam int PCR_CFG_INV_BIT   = 3;
   localparam int PCR_SMOOTH_LSB    = 8;
   localparam int PCR_ADC_PD_BIT    = 7;
   localparam int PCR_VBUF_PD_BIT   = 6;
   localparam int PCR_VREF_PD_BIT   = 5;
   localparam int PCR_DAC0_PD_BIT   = 3;
   localparam int PCR_DAC3_PD_BIT   = 0;
   localparam int PCR_AUX_EN_BIT    = 15;
   localparam int PCR_OSC_PD_BIT    = 2;
   localparam int PCR_DAC_INIT_LSB  = 0;

   // ==========================================================
   // Pin channel map for the auxiliary converter
   localparam int PCR_AUX_PIN_CH0 = 9;
   localparam int PCR_AUX_PIN_CH1 = 2;
   localparam int PCR_AUX_PIN_CH2 = 3;
   localparam int PCR_AUX_PIN_CH3 = 8;

   // ==========================================================
   // Reset values
   localparam logic [23:0] PCR_RST_PIN  = 24'h000000;
   localparam logic [1:0]  PCR_RST_2B   = 2'h0;
   localparam logic [3:0]  PCR_RST_4B   = 4'h0;
   localparam logic        PCR_RST_BIT  = 1'b0;

   // ==========================================================
   // Field codes (low three bits; bit 3 is inversion)
   localparam logic [2:0] PCR_FN_GPI_DEB   = 3'h0;
   localparam logic [2:0] PCR_FN_GPI_RAW   = 3'h1;
   localparam logic [2:0] PCR_FN_GPO       = 3'h2;
   localparam logic [2:0] PCR_FN_OPEN_COLL = 3'h3;
   localparam logic [2:0] PCR_FN_SERIAL    = 3'h4;
   localparam logic [3:0] PCR_CODE_AUX     = 4'hf;

   // Smoothing select codes
   localparam logic [1:0] PCR_SM_HYST4  = 2'h0;
   localparam logic [1:0] PCR_SM_HYST5  = 2'h1;
   localparam logic [1:0] PCR_SM_BYPASS = 2'h2;
   localparam logic [1:0] PCR_SM_NO_LPF = 2'h3;

   // Pin function selection as decoded from one field
   typedef enum {
      PCR_PIN_GPI_DEB,
      PCR_PIN_GPI_RAW,
      PCR_PIN_GPO,
      PCR_PIN_OPEN_COLL,
      PCR_PIN_SERIAL,
      PCR_PIN_AUX,
      PCR_PIN_NONE
   } pcr_pin_fn_t;
endpackage

// *** logic/pcr_pin_decode.sv ***
// Decoder of one multipurpose pin configuration field
`timescale 1ns/1ps
module pcr_pin_decode #(
   parameter bit SERIAL_IS_INPUT = 1'b1,
   parameter bit AUX_CAPABLE     = 1'b0
) (
   // Field
   input  wire logic [pcr_pkg::PCR_CFG_W-1:0] multipurpose_pin_cfg,
   // Decoded selection
   output logic                               sel_gpi_deb,
   output logic                               sel_gpi_raw,
   output logic                               sel_gpo,
   output logic                               sel_open_coll,
   output logic                               sel_serial_in,
   output logic                               sel_serial_out,
   output logic                               sel_aux,
   output logic                               invert,
   output logic                               pullup_en
);
   import pcr_pkg::*;

   pcr_pin_fn_t fn;

   // ==========================================================
   // Function select
   always_comb begin
      if (multipurpose_pin_cfg == PCR_CODE_AUX) begin
         // Non-capable pins have no converter path at all
         fn = AUX_CAPABLE ? PCR_PIN_AUX : PCR_PIN_NONE;
      end else begin
         case (multipurpose_pin_cfg[2:0])
            PCR_FN_GPI_DEB:   fn = PCR_PIN_GPI_DEB;
            PCR_FN_GPI_RAW:   fn = PCR_PIN_GPI_RAW;
            PCR_FN_GPO:       fn = PCR_PIN_GPO;
            PCR_FN_OPEN_COLL: fn = PCR_PIN_OPEN_COLL;
            PCR_FN_SERIAL:    fn = PCR_PIN_SERIAL;
            default:          fn = PCR_PIN_NONE;
         endcase
      end
   end

   always_comb begin
      sel_gpi_deb    = (fn == PCR_PIN_GPI_DEB);
      sel_gpi_raw    = (fn == PCR_PIN_GPI_RAW);
      sel_gpo        = (fn == PCR_PIN_GPO);
      sel_open_coll  = (fn == PCR_PIN_OPEN_COLL);
      sel_serial_in  = (fn == PCR_PIN_SERIAL) && SERIAL_IS_INPUT;
      sel_serial_out = (fn == PCR_PIN_SERIAL) && !SERIAL_IS_INPUT;
      sel_aux        = (fn == PCR_PIN_AUX);
      // Analog and undefined codes never invert
      invert = multipurpose_pin_cfg[PCR_CFG_INV_BIT] &&
               (fn != PCR_PIN_AUX) && (fn != PCR_PIN_NONE);
      pullup_en = sel_gpi_deb || sel_gpi_raw || sel_serial_in;
   end
endmodule

// *** verification/pcr_regs_checker.sv ***
// Checker: port-level assertions for the pin function and power bank
`timescale 1ns/1ps
module pcr_regs_checker (
   // Clock and reset
   input wire logic                             clk,
   input wire logic                             rst,
   // Register access
   input wire logic                             reg_wr,
   input wire logic                             reg_rd,
   input wire logic [pcr_pkg::PCR_ADDR_W-1:0]   reg_addr,
   input wire logic [pcr_pkg::PCR_DATA_W-1:0]   reg_wdata,
   input wire logic                             reg_rvalid,
   // Pin selection
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_gpi_debounced,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_gpi_raw,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_gpo,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_open_collector,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_serial_in,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_serial_out,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_aux_in,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_invert,
   input wire logic [pcr_pkg::PCR_NUM_PINS-1:0] pin_pullup_en,
   // Converter and power
   input wire logic [3:0]                       aux_channel_connect,
   input wire logic                             aux_converter_enable,
   input wire logic [1:0]                       aux_smoothing_select,
   input wire logic                             aux_lpf_active,
   input wire logic                             adc_power_down,
   input wire logic                             oscillator_power_down
);
   import pcr_pkg::*;
   // ==========================================================
   // Write data two edges back, when derived outputs land
   logic [23:0] wd1_q;
   logic [23:0] wd2_q;
   always_ff @(posedge clk) begin
      wd1_q <= reg_wdata;
      wd2_q <= wd1_q;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence wr_to(logic [15:0] a);
      reg_wr && reg_addr == a;
   endsequence
   // ==========================================================
   // Assertions
   rd_answer_a:
      assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
   rvalid_cause_a:
      assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read valid without read");
   pullup_input_a:
      assert property (pin_pullup_en ==
         (pin_gpi_debounced | pin_gpi_raw | pin_serial_in))
      else $error("pull-up not tied to digital input");
   invert_func_a:
      assert property ((pin_invert & ~(pin_gpi_debounced | pin_gpi_raw |
         pin_gpo | pin_open_collector | pin_serial_in | pin_serial_out))
         == '0) else $error("invert without function");
   serial_split_a:
      assert property (pin_serial_in[11:6] == '0 && pin_serial_out[5:0] == '0)
      else $error("serial direction on wrong pins");
   aux_map_a:
      assert property ((pin_aux_in & 12'hcf3) == '0 && aux_channel_connect
         == {pin_aux_in[8], pin_aux_in[3], pin_aux_in[2], pin_aux_in[9]})
      else $error("aux channel map wrong");
   lpf_default_a:
      assert property (aux_lpf_active ==
         (aux_converter_enable && !aux_smoothing_select[1]))
      else $error("low-pass state wrong");
   adc_pd_land_a:
      assert property (wr_to(PCR_ADDR_PWR) |-> ##2 adc_power_down == wd2_q[7])
      else $error("adc power-down not from bit 7");
   smooth_land_a:
      assert property (wr_to(PCR_ADDR_PWR) |->
         ##2 aux_smoothing_select == wd2_q[9:8])
      else $error("smoothing not from bits 9:8");
   aux_en_land_a:
      assert property (wr_to(PCR_ADDR_AUX_EN) |->
         ##2 aux_converter_enable == wd2_q[15])
      else $error("aux enable not from bit 15");
   osc_pd_land_a:
      assert property (wr_to(PCR_ADDR_OSC) |->
         ##2 oscillator_power_down == wd2_q[2])
      else $error("oscillator power-down not from bit 2");
endmodule

bind pcr_regs pcr_regs_checker chk_u (.clk, .rst, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rvalid, .pin_gpi_debounced, .pin_gpi_raw,
   .pin_gpo, .pin_open_collector, .pin_serial_in, .pin_serial_out,
   .pin_aux_in, .pin_invert, .pin_pullup_en, .aux_channel_connect,
   .aux_converter_enable, .aux_smoothing_select, .aux_lpf_active,
   .adc_power_down, .oscillator_power_down);

// *** verification/pin_function_and_power_regs_tb_top.sv ***
// Testbench: register access tests of the pin function and power bank
`timescale 1ns/1ps
module pin_function_and_power_regs_tb_top;
   import pcr_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [23:0] reg_wdata = 24'h000000;
   logic [23:0] reg_rdata;
   logic        reg_rvalid;
   logic [11:0] pin_gpi_debounced, pin_gpi_raw, pin_gpo, pin_open_collector;
   logic [11:0] pin_serial_in, pin_serial_out, pin_aux_in, pin_invert;
   logic [11:0] pin_pullup_en;
   logic [3:0]  aux_channel_connect;
   logic [1:0]  aux_smoothing_select, dac_init_code;
   logic        aux_converter_enable, aux_lpf_active, aux_hyst_active;
   logic        aux_hyst_5bit, adc_power_down, vref_buffer_power_down;
   logic        vref_power_down, dac0_power_down, dac1_power_down;
   logic        dac2_power_down, dac3_power_down, oscillator_power_down;
   logic [111:0] pins;
   logic [9:0]   pwr;
   logic [15:0]  addrs [6] = '{16'h0820, 16'h0821, 16'h0822, 16'h0824,
                               16'h0826, 16'h0827};
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   pcr_regs dut_u (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .pin_gpi_debounced, .pin_gpi_raw, .pin_gpo,
      .pin_open_collector, .pin_serial_in, .pin_serial_out, .pin_aux_in,
      .pin_invert, .pin_pullup_en, .aux_channel_connect,
      .aux_converter_enable, .aux_smoothing_select, .aux_lpf_active,
      .aux_hyst_active, .aux_hyst_5bit, .adc_power_down,
      .vref_buffer_power_down, .vref_power_down, .dac0_power_down,
      .dac1_power_down, .dac2_power_down, .dac3_power_down,
      .oscillator_power_down, .dac_init_code);

   assign pins = {pin_gpi_debounced, pin_gpi_raw, pin_gpo, pin_open_collector,
      pin_serial_in, pin_serial_out, pin_aux_in, pin_invert, pin_pullup_en,
      aux_channel_connect};
   assign pwr = {aux_smoothing_select, adc_power_down, vref_buffer_power_down,
      vref_power_down, 1'b0, dac0_power_down, dac1_power_down,
      dac2_power_down, dac3_power_down};

   // ==========================================================
   // Closing report
   task automatic stop_test;
      $display("TB: checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [111:0] seen, logic [111:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // ==========================================================
   // Control port access; strobes stay up between calls
   task automatic wr(logic [15:0] a, logic [23:0] d);
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
   endtask

   task automatic rd(logic [15:0] a, logic [23:0] exp);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      chk("rvalid", reg_rvalid, 1'b1);
      chk($sformatf("rdata %h", a), reg_rdata, exp);
   endtask

   task automatic idle;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      @(negedge clk);
   endtask

   function automatic logic [111:0] exp_pins(logic [3:0] c);
      logic       dig;
      logic [2:0] f;
      logic [11:0] sin;
      f = c[2:0];
      dig = f <= 3'h4;
      sin = (dig && f == 3'h4) ? 12'h03f : 12'h000;
      return {{12{dig && f == 3'h0}}, {12{dig && f == 3'h1}},
              {12{dig && f == 3'h2}}, {12{dig && f == 3'h3}}, sin,
              (dig && f == 3'h4) ? 12'hfc0 : 12'h000,
              (c == 4'hf) ? 12'h30c : 12'h000, {12{dig && c[3]}},
              {12{dig && f < 3'h2}} | sin, (c == 4'hf) ? 4'hf : 4'h0};
   endfunction

   task automatic check_reset;
      foreach (addrs[i]) rd(addrs[i], 24'h000000);
      idle;
      chk("rvalid low", reg_rvalid, 1'b0);
      chk("reset pins", pins, exp_pins(4'h0));
      chk("reset power", {pwr, aux_converter_enable, oscillator_power_down,
         dac_init_code}, '0);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         stop_test();
      end
   end

   initial begin
      logic [3:0]  c;
      logic [1:0]  s;
      logic [23:0] d;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check_reset();
      for (int k = 0; k < 16; k++) begin
         if (k inside {5, 6, 7, 13, 14}) continue;
         c = 4'(k);
         wr(PCR_ADDR_PIN_LOW, {6{c}});
         wr(PCR_ADDR_PIN_HIGH, {6{c}});
         rd(PCR_ADDR_PIN_LOW, {6{c}});
         rd(PCR_ADDR_PIN_HIGH, {6{c}});
         idle;
         chk("pin code", pins, exp_pins(c));
      end
      wr(PCR_ADDR_PIN_LOW, 24'hf43210);
      wr(PCR_ADDR_PIN_HIGH, 24'h8af432);
      idle;
      idle;
      chk("pin fields", pins, {12'h801, 12'h002, 12'h444, 12'h088, 12'h010,
         12'h100, 12'h200, 12'hc00, 12'h813, 4'h1});
      for (int k = 0; k < 24; k++) begin
         d = 24'h000001 << k;
         wr(PCR_ADDR_PWR, d);
         rd(PCR_ADDR_PWR, d & 24'h0003ef);
         idle;
         chk("power bits", pwr, 10'(d & 24'h0003ef));
      end
      for (int e = 0; e < 2; e++) begin
         for (int k = 0; k < 4; k++) begin
            s = 2'(k);
            wr(PCR_ADDR_AUX_EN, (e == 1) ? 24'hffffff : 24'hff7fff);
            rd(PCR_ADDR_AUX_EN, (e == 1) ? 24'h008000 : 24'h0);
            wr(PCR_ADDR_PWR, {14'h0, s, 8'h00});
            idle;
            chk("smoothing", {aux_converter_enable, aux_smoothing_select,
               aux_lpf_active, aux_hyst_active, aux_hyst_5bit},
               {e == 1, s, e == 1 && !s[1], e == 1 && s != 2'h2,
               s == 2'h1});
         end
      end
      for (int k = 0; k < 2; k++) begin
         wr(PCR_ADDR_OSC, (k == 0) ? 24'hffffff : 24'hfffffb);
         rd(PCR_ADDR_OSC, (k == 0) ? 24'h000004 : 24'h0);
         idle;
         chk("osc", oscillator_power_down, k == 0);
      end
      for (int k = 0; k < 2; k++) begin
         // Only the initialise code is legal; reserved neighbours toggle
         wr(PCR_ADDR_DAC_INIT, 24'h000001 | (24'hfffffc & {24{k[0]}}));
         rd(PCR_ADDR_DAC_INIT, 24'h000001);
         idle;
         chk("dac init", dac_init_code, 2'h1);
      end
      // Unmapped holes must neither store nor disturb neighbours
      wr(16'h0823, 24'hffffff);
      wr(16'h0825, 24'hffffff);
      rd(16'h0823, 24'h0);
      rd(16'h0828, 24'h0);
      rd(PCR_ADDR_PIN_HIGH, 24'h8af432);
      idle;
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      check_reset();
      stop_test();
   end
endmodule
